// ### core/rhs_hub_status.sv
`timescale 1ns/1ps

module rhs_hub_status #(
	parameter int NPORTS = rhs_pkg::NUM_PORTS
) (
	input  wire logic                 mclk,
	input  wire logic                 rst,
	input  wire rhs_pkg::rhs_reg_req_t reg_req,
	output logic      [31:0]          reg_rdata,
	input  wire logic                 overcurrent_pin,
	input  wire logic                 oc_per_port,
	input  wire logic                 supply_switching_select,
	input  wire logic [NPORTS-1:0]    port_supply_mask,
	input  wire logic [NPORTS-1:0]    attach_change_flag,
	input  wire logic                 suspended_state,
	output logic      [NPORTS-1:0]    port_supply_on,
	output logic      [NPORTS-1:0]    port_supply_off,
	output logic                      resume_req,
	output logic                      resume_seen_interrupt,
	output logic                      remote_wakeup_enable,
	output logic                      global_overcurrent_flag,
	output logic                      overcurrent_change_flag
);

	// ------------------------------------------------------------
	// Access decode
	// ------------------------------------------------------------
	logic wr_hit;
	logic rd_hit;
	logic oc_sync;
	logic next_global_oc;
	logic attach_any;
	logic attach_any_q;
	logic [NPORTS-1:0] cmd_ports;

	assign wr_hit = reg_req.wr && (reg_req.addr == rhs_pkg::HUB_STATUS_OFFSET);
	assign rd_hit = reg_req.rd && (reg_req.addr == rhs_pkg::HUB_STATUS_OFFSET);

	// Reserved write bits are ignored, so careless software cannot disturb state.
	logic clr_wake_cmd;
	logic set_wake_cmd;
	logic clr_oc_change_cmd;
	logic set_all_port_power_cmd;
	logic clear_all_port_power_cmd;

	assign clr_wake_cmd             = wr_hit && reg_req.wdata[rhs_pkg::CLR_WAKE_BIT];
	assign set_wake_cmd             = wr_hit && reg_req.wdata[rhs_pkg::WAKE_EN_BIT];
	assign clr_oc_change_cmd        = wr_hit && reg_req.wdata[rhs_pkg::OC_CHANGE_BIT];
	assign set_all_port_power_cmd   = wr_hit && reg_req.wdata[rhs_pkg::SET_POWER_BIT];
	assign clear_all_port_power_cmd = wr_hit && reg_req.wdata[rhs_pkg::CLR_POWER_BIT];

	// ------------------------------------------------------------
	// Overcurrent
	// ------------------------------------------------------------
	rhs_sync #(
		.WIDTH (1)
	) u_oc_sync (
		.mclk (mclk),
		.rst  (rst),
		.din  (overcurrent_pin),
		.dout (oc_sync)
	);

	assign next_global_oc = oc_per_port ? 1'b0 : oc_sync;

	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
			global_overcurrent_flag <= 1'b0;
		else
			global_overcurrent_flag <= next_global_oc;
	end

	// A change arriving with a clear write wins, so no event is lost.
	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
			overcurrent_change_flag <= 1'b0;
		else if (next_global_oc != global_overcurrent_flag)
			overcurrent_change_flag <= 1'b1;
		else if (clr_oc_change_cmd)
			overcurrent_change_flag <= 1'b0;
	end

	// ------------------------------------------------------------
	// Remote wakeup enable
	// ------------------------------------------------------------
	// When both set and clear are written together the clear wins, the safer state.
	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
			remote_wakeup_enable <= 1'b0;
		else if (clr_wake_cmd)
			remote_wakeup_enable <= 1'b0;
		else if (set_wake_cmd)
			remote_wakeup_enable <= 1'b1;
	end

	// ------------------------------------------------------------
	// Resume detection
	// ------------------------------------------------------------
	assign attach_any = |attach_change_flag;

	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
			attach_any_q <= 1'b0;
		else
			attach_any_q <= attach_any;
	end

	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
		begin
			resume_req            <= 1'b0;
			resume_seen_interrupt <= 1'b0;
		end
		else
		begin
			resume_req            <= remote_wakeup_enable && suspended_state && attach_any && !attach_any_q;
			resume_seen_interrupt <= remote_wakeup_enable && suspended_state && attach_any && !attach_any_q;
		end
	end

	// ------------------------------------------------------------
	// Global power commands
	// ------------------------------------------------------------
	// With supply_switching_select set, ports with a set mask bit answer only to their own per-port commands.
	assign cmd_ports = supply_switching_select ? ~port_supply_mask : {NPORTS{1'b1}};

	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
		begin
			port_supply_on  <= '0;
			port_supply_off <= '0;
		end
		else
		begin
			port_supply_on  <= set_all_port_power_cmd ? cmd_ports : '0;
			port_supply_off <= clear_all_port_power_cmd ? cmd_ports : '0;
		end
	end

	// ------------------------------------------------------------
	// Read data
	// ------------------------------------------------------------
	// Command bits 31, 16 and 0 have no state behind them and read as zero.
	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
			reg_rdata <= rhs_pkg::HUB_STATUS_RESET;
		else if (rd_hit)
		begin
			reg_rdata                         <= rhs_pkg::HUB_STATUS_RESET;
			reg_rdata[rhs_pkg::OC_CHANGE_BIT] <= overcurrent_change_flag;
			reg_rdata[rhs_pkg::WAKE_EN_BIT]   <= remote_wakeup_enable;
			reg_rdata[rhs_pkg::OC_BIT]        <= global_overcurrent_flag;
		end
		else
			reg_rdata <= '0;
	end

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (rst);

	field_layout_a: assert property (rd_hit |=> reg_rdata[17] == $past(overcurrent_change_flag)
		&& reg_rdata[15] == $past(remote_wakeup_enable) && reg_rdata[1] == $past(global_overcurrent_flag))
		else $error("Read data does not match the status fields.");
	wake_clear_a: assert property (clr_wake_cmd |=> !remote_wakeup_enable)
		else $error("Clear-wakeup write left the enable set.");
	oc_change_set_a: assert property ($changed(global_overcurrent_flag) |-> overcurrent_change_flag)
		else $error("Overcurrent change not flagged.");
	oc_change_clr_a: assert property (clr_oc_change_cmd && next_global_oc == global_overcurrent_flag
		|=> !overcurrent_change_flag)
		else $error("Overcurrent change flag not cleared.");
	oc_change_hold_a: assert property (overcurrent_change_flag && !clr_oc_change_cmd
		|=> overcurrent_change_flag)
		else $error("Overcurrent change flag dropped without a clear.");
	zero_bits_a: assert property (reg_rdata[16] == 1'b0 && reg_rdata[0] == 1'b0
		&& reg_rdata[31] == 1'b0)
		else $error("Command bits read non-zero.");
	global_on_a: assert property (set_all_port_power_cmd && !supply_switching_select
		|=> port_supply_on == {NPORTS{1'b1}})
		else $error("Global power-on missed a port.");
	masked_on_a: assert property (set_all_port_power_cmd && supply_switching_select
		|=> port_supply_on == ~$past(port_supply_mask))
		else $error("Per-port power-on ignored the mask.");
	global_off_a: assert property (clear_all_port_power_cmd && !supply_switching_select
		|=> port_supply_off == {NPORTS{1'b1}})
		else $error("Global power-off missed a port.");
	masked_off_a: assert property (clear_all_port_power_cmd && supply_switching_select
		|=> port_supply_off == ~$past(port_supply_mask))
		else $error("Per-port power-off ignored the mask.");
	no_cmd_power_a: assert property (!set_all_port_power_cmd && !clear_all_port_power_cmd
		|=> port_supply_on == '0 && port_supply_off == '0)
		else $error("Port power pulse without a command.");
	resume_event_a: assert property (remote_wakeup_enable && suspended_state && $rose(attach_any)
		|=> resume_req && resume_seen_interrupt)
		else $error("Wakeup event did not request resume.");
	resume_gate_a: assert property (!remote_wakeup_enable |=> !resume_req)
		else $error("Resume requested with wakeup disabled.");
	wake_set_a: assert property (set_wake_cmd && !clr_wake_cmd |=> remote_wakeup_enable)
		else $error("Set-wakeup write left the enable clear.");
	oc_report_a: assert property (!oc_per_port && oc_sync |=> global_overcurrent_flag)
		else $error("Overcurrent not reported.");
	per_port_oc_a: assert property (oc_per_port |=> !global_overcurrent_flag)
		else $error("Global overcurrent shown in per-port mode.");

	resume_c: cover property (resume_req);
	oc_change_c: cover property (overcurrent_change_flag ##1 clr_oc_change_cmd ##1 !overcurrent_change_flag);
	masked_on_c: cover property (set_all_port_power_cmd && supply_switching_select && |port_supply_mask);
	wake_toggle_c: cover property (set_wake_cmd ##[1:4] clr_wake_cmd);

endmodule // rhs_hub_status

// ### core/rhs_pkg.sv
package rhs_pkg;

	// ------------------------------------------------------------
	// Register placement and reset
	// ------------------------------------------------------------
	localparam logic [7:0]  HUB_STATUS_OFFSET = 8'h50;
	localparam logic [31:0] HUB_STATUS_RESET  = 32'h0000_0000;

	// ------------------------------------------------------------
	// Field positions
	// ------------------------------------------------------------
	localparam int CLR_WAKE_BIT  = 31;
	localparam int OC_CHANGE_BIT = 17;
	localparam int SET_POWER_BIT = 16;
	localparam int WAKE_EN_BIT   = 15;
	localparam int OC_BIT        = 1;
	localparam int CLR_POWER_BIT = 0;

	// ------------------------------------------------------------
	// Defaults
	// ------------------------------------------------------------
	localparam int NUM_PORTS   = 4;
	localparam int SYNC_STAGES = 2;

	typedef struct packed {
		logic        wr;
		logic        rd;
		logic [7:0]  addr;
		logic [31:0] wdata;
	} rhs_reg_req_t;

endpackage

// ### core/rhs_sync.sv
`timescale 1ns/1ps

module rhs_sync #(
	parameter int WIDTH = 1
) (
	input  wire logic             mclk,
	input  wire logic             rst,
	input  wire logic [WIDTH-1:0] din,
	output logic      [WIDTH-1:0] dout
);

	// First stage is read only by the second stage.
	logic [WIDTH-1:0] stage1;

	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
		begin
			stage1 <= '0;
			dout   <= '0;
		end
		else
		begin
			stage1 <= din;
			dout   <= stage1;
		end
	end

endmodule // rhs_sync

// ### test/tb_top.sv
`timescale 1ns/1ps

module tb_top;
	logic                  mclk;
	logic                  rst;
	rhs_pkg::rhs_reg_req_t reg_req;
	logic [31:0]           reg_rdata;
	logic                  overcurrent_pin;
	logic                  oc_per_port;
	logic                  supply_switching_select;
	logic [3:0]            port_supply_mask;
	logic [3:0]            attach_change_flag;
	logic                  suspended_state;
	logic [3:0]            port_supply_on;
	logic [3:0]            port_supply_off;
	logic                  resume_req;
	logic                  resume_seen_interrupt;
	logic                  remote_wakeup_enable;
	logic                  global_overcurrent_flag;
	logic                  overcurrent_change_flag;
	int                    miscompares;
	int                    tests_run;
	logic [31:0]           seed;
	logic [31:0]           r;

	rhs_hub_status #(.NPORTS(4)) u_rhs_hub_status (
		.mclk                    (mclk),
		.rst                     (rst),
		.reg_req                 (reg_req),
		.reg_rdata               (reg_rdata),
		.overcurrent_pin         (overcurrent_pin),
		.oc_per_port             (oc_per_port),
		.supply_switching_select (supply_switching_select),
		.port_supply_mask        (port_supply_mask),
		.attach_change_flag      (attach_change_flag),
		.suspended_state         (suspended_state),
		.port_supply_on          (port_supply_on),
		.port_supply_off         (port_supply_off),
		.resume_req              (resume_req),
		.resume_seen_interrupt   (resume_seen_interrupt),
		.remote_wakeup_enable    (remote_wakeup_enable),
		.global_overcurrent_flag (global_overcurrent_flag),
		.overcurrent_change_flag (overcurrent_change_flag)
	);

	// ------------------------------------------------------------
	// Clock, helpers and bus tasks
	// ------------------------------------------------------------
	initial
	begin
		mclk = 1'b0;
		forever #2 mclk = ~mclk;
	end

	function automatic logic [31:0] xs();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction

	// A masked port only follows global commands when switching is global.
	function automatic logic [3:0] exp_pwr(input logic cmd, input logic sel, input logic [3:0] m);
		return cmd ? (sel ? ~m : 4'hf) : 4'h0;
	endfunction

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string msg);
		tests_run++;
		if (seen !== exp)
		begin
			$display("unexpected at %0t: %s seen %h expected %h", $time, msg, seen, exp);
			miscompares++;
		end
	endtask

	// Tasks start and end at a falling edge; the answer is visible after one rising edge.
	// Each transfer first lets one clock pass, so a strobe lowered by the previous call is never raised again at once.
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(negedge mclk);
		reg_req.wr    = 1'b1;
		reg_req.addr  = a;
		reg_req.wdata = d;
		@(negedge mclk);
		reg_req.wr    = 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] e, input string msg);
		@(negedge mclk);
		reg_req.rd   = 1'b1;
		reg_req.addr = a;
		@(negedge mclk);
		reg_req.rd   = 1'b0;
		chk(reg_rdata, e, msg);
	endtask

	task automatic end_sim();
		$display("comparisons %0d miscompares %0d", tests_run, miscompares);
		if (miscompares == 0 && tests_run > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	initial
	begin
		#20000;
		miscompares++;
		end_sim();
	end

	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial
	begin
		seed = 32'he847;
		reg_req = '0;
		overcurrent_pin = 1'b0;
		oc_per_port = 1'b0;
		supply_switching_select = 1'b0;
		port_supply_mask = 4'h0;
		attach_change_flag = 4'h0;
		suspended_state = 1'b0;
		miscompares = 0;
		tests_run = 0;
		rst = 1'b1;
		repeat (3) @(negedge mclk);
		rst = 1'b0;
		chk({remote_wakeup_enable, global_overcurrent_flag, overcurrent_change_flag}, 32'h0, "reset");
		rd(8'h50, 32'h0000_0000, "reset value");
		wr(8'h54, 32'h0000_8000);
		rd(8'h54, 32'h0000_0000, "unmapped read");
		chk(remote_wakeup_enable, 32'h0, "unmapped write");
		wr(8'h50, 32'h0000_8000);
		rd(8'h50, 32'h0000_8000, "wake readback");
		wr(8'h50, 32'h0000_0000);
		chk(remote_wakeup_enable, 32'h1, "zero keeps wake");
		wr(8'h50, 32'h8000_0000);
		chk(remote_wakeup_enable, 32'h0, "wake clear");
		wr(8'h50, 32'h8000_8000);
		chk(remote_wakeup_enable, 32'h0, "clear wins");
		// Random power commands; reserved bits are always written as zero.
		for (int i = 0; i < 40; i++)
		begin
			r = xs();
			supply_switching_select = r[8];
			port_supply_mask = r[7:4];
			wr(8'h50, {15'h0, r[16], 15'h0, r[0]});
			chk({28'h0, port_supply_on}, {28'h0, exp_pwr(r[16], r[8], r[7:4])}, "on");
			chk({28'h0, port_supply_off}, {28'h0, exp_pwr(r[0], r[8], r[7:4])}, "off");
			rd(8'h50, 32'h0000_0000, "command bits read");
			chk({port_supply_on, port_supply_off}, 32'h0, "pulse ends");
		end
		// Overcurrent passes two sync stages before it is reported.
		overcurrent_pin = 1'b1;
		repeat (2) @(negedge mclk);
		chk(global_overcurrent_flag, 32'h0, "sync delay");
		@(negedge mclk);
		chk({global_overcurrent_flag, overcurrent_change_flag}, 32'h3, "oc rise");
		rd(8'h50, 32'h0002_0002, "oc read");
		wr(8'h50, 32'h0000_0000);
		chk(overcurrent_change_flag, 32'h1, "zero keeps change");
		wr(8'h50, 32'h0002_0000);
		chk(overcurrent_change_flag, 32'h0, "change clear");
		overcurrent_pin = 1'b0;
		repeat (3) @(negedge mclk);
		chk({global_overcurrent_flag, overcurrent_change_flag}, 32'h1, "oc fall");
		wr(8'h50, 32'h0002_0000);
		oc_per_port = 1'b1;
		overcurrent_pin = 1'b1;
		repeat (4) @(negedge mclk);
		rd(8'h50, 32'h0000_0000, "per port hides oc");
		overcurrent_pin = 1'b0;
		repeat (4) @(negedge mclk);
		oc_per_port = 1'b0;
		// Every enable and suspend pairing; only both together give a resume.
		for (int k = 0; k < 4; k++)
		begin
			wr(8'h50, k[0] ? 32'h0000_8000 : 32'h8000_0000);
			suspended_state = k[1];
			attach_change_flag = 4'h0;
			@(negedge mclk);
			attach_change_flag = 4'h4;
			@(negedge mclk);
			chk({resume_req, resume_seen_interrupt}, (k == 3) ? 32'h3 : 32'h0, "resume");
			attach_change_flag = 4'h6;
			@(negedge mclk);
			chk({resume_req, resume_seen_interrupt}, 32'h0, "no second resume");
		end
		// A reset in mid-run must drop flags that are set at that moment.
		overcurrent_pin = 1'b1;
		repeat (3) @(negedge mclk);
		chk({remote_wakeup_enable, global_overcurrent_flag, overcurrent_change_flag}, 32'h7, "armed");
		overcurrent_pin = 1'b0;
		rst = 1'b1;
		@(negedge mclk);
		rst = 1'b0;
		chk({remote_wakeup_enable, global_overcurrent_flag, overcurrent_change_flag}, 32'h0, "mid reset");
		rd(8'h50, 32'h0000_0000, "mid reset read");
		end_sim();
	end
endmodule // tb_top
